// File: rtl/cprpd_pkg.sv
// cprpd_pkg: register map, field layout and reset values of the
// request router and its two priority decoders.
// assumes a 32-bit apb slave with one aligned word per register.
package cprpd_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_CP_CTRL = 12'h000;
  localparam logic [11:0] OFF_CP_PRIO = 12'h004;
  localparam logic [11:0] OFF_VEC_BASE = 12'h008;
  localparam logic [11:0] OFF_CP_VEC_BASE = 12'h00C;
  localparam logic [11:0] OFF_SPUR_VEC = 12'h010;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h014;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
  localparam logic [11:0] OFF_CPU_STATE = 12'h01C;
  localparam logic [11:0] OFF_CP_STATE = 12'h020;
  // channel_config_data words start here, one word per channel
  localparam logic [11:0] OFF_CHAN_CFG = 12'h040;

  // channel_config_data fields
  localparam int CFG_LVL_LSB = 0;
  localparam int CFG_LVL_W = 3;
  localparam int CFG_ROUTE_BIT = 7;

  // coprocessor control fields
  localparam int CTRL_IRQ_EN_BIT = 0;

  // status / mask bits
  localparam int ST_W = 4;
  localparam int ST_VEC_DONE = 0;
  localparam int ST_SPURIOUS = 1;
  localparam int ST_OVERRIDE = 2;
  localparam int ST_CP_TAKEN = 3;

  // vector width and reset values
  localparam int VEC_W = 16;
  localparam logic [2:0] RST_LVL = 3'h0;
  localparam logic [2:0] RST_CP_PRIO = 3'h0;
  localparam logic [15:0] RST_VEC_BASE = 16'hFF00;
  localparam logic [15:0] RST_CP_VEC_BASE = 16'hFE00;
  localparam logic [15:0] RST_SPUR_VEC = 16'hFF10;
  localparam logic [ST_W-1:0] RST_MASK = 4'h0;
endpackage : cprpd_pkg

// File: rtl/cprpd_top.sv
// cprpd_top: routes request channels to the cpu or the coprocessor,
// resolves a cpu vector on demand and hands coprocessor requests over.
// assumes request levels, coprocessor flags and cpu/coprocessor strobes
// are synchronous to pclk; registers sit behind a zero-wait-plus-one apb.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cprpd_top #(
  parameter int NUM_CHAN = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,

  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,

  // request sources
  input wire logic [NUM_CHAN-1:0] irq_req,
  input wire logic [NUM_CHAN-1:0] cp_flag,

  // cpu side
  output logic cpu_irq,
  output logic [2:0] cpu_irq_level,
  input wire logic cpu_vec_req,
  output logic cpu_vec_valid,
  output logic [cprpd_pkg::VEC_W-1:0] cpu_vec,

  // coprocessor side
  output logic cp_req_valid,
  output logic [$clog2(NUM_CHAN)-1:0] cp_req_chan,
  output logic cp_req_prio,
  input wire logic cp_req_ack,

  // interrupt to the cpu for this block's own events
  output logic blk_irq
);
  localparam int CW = (NUM_CHAN > 1) ? $clog2(NUM_CHAN) : 1;
  localparam int VW = cprpd_pkg::VEC_W;

  // configuration state
  logic [2:0] chan_lvl [NUM_CHAN];
  logic [NUM_CHAN-1:0] route_to_coprocessor;
  logic coprocessor_irq_enable;
  logic [2:0] coprocessor_irq_priority_cfg;

  // vector bases, bit 0 always low
  logic [VW-1:0] vec_base;
  logic [VW-1:0] cp_vec_base;
  logic [VW-1:0] spur_vec;
  logic [cprpd_pkg::ST_W-1:0] irq_status;
  logic [cprpd_pkg::ST_W-1:0] irq_mask;

  // vector recognised when cpu_irq first rose, for override detection;
  // only feeds the status bit, never the vector the cpu receives
  logic [VW-1:0] recog_vec;
  logic recog_valid;

  // apb decode
  wire logic setup_ph = psel & ~penable;
  wire logic done_ph = psel & penable & pready;
  wire logic wr_done = done_ph & pwrite;
  wire logic rd_done = done_ph & ~pwrite;
  wire logic chan_hit = (paddr >= cprpd_pkg::OFF_CHAN_CFG) &&
      (paddr < cprpd_pkg::OFF_CHAN_CFG + 12'(4 * NUM_CHAN)) &&
      (paddr[1:0] == 2'b00);
  wire logic [11:0] chan_off = paddr - cprpd_pkg::OFF_CHAN_CFG;
  wire logic [CW-1:0] chan_idx = chan_off[CW+1:2];
  wire logic hit_ctrl = (paddr == cprpd_pkg::OFF_CP_CTRL);
  wire logic hit_prio = (paddr == cprpd_pkg::OFF_CP_PRIO);
  wire logic hit_vbase = (paddr == cprpd_pkg::OFF_VEC_BASE);
  wire logic hit_cpvbase = (paddr == cprpd_pkg::OFF_CP_VEC_BASE);
  wire logic hit_spur = (paddr == cprpd_pkg::OFF_SPUR_VEC);
  wire logic hit_status = (paddr == cprpd_pkg::OFF_IRQ_STATUS);
  wire logic hit_mask = (paddr == cprpd_pkg::OFF_IRQ_MASK);
  wire logic hit_cpu_st = (paddr == cprpd_pkg::OFF_CPU_STATE);
  wire logic hit_cp_st = (paddr == cprpd_pkg::OFF_CP_STATE);
  // anything outside this set answers with pslverr
  wire logic addr_ok = chan_hit |
      hit_ctrl |
      hit_prio |
      hit_vbase |
      hit_cpvbase |
      hit_spur |
      hit_status |
      hit_mask |
      hit_cpu_st |
      hit_cp_st;

  // cpu decoder: ordinary channels and coprocessor-raised flags compete
  logic cpu_any;
  logic [2:0] cpu_best_lvl;
  logic [VW-1:0] cpu_best_vec;
  always_comb begin
    logic [VW-1:0] v;
    v = '0;
    cpu_any = 1'b0;
    cpu_best_lvl = 3'h0;
    cpu_best_vec = '0;
    for (int i = 0; i < NUM_CHAN; i++) begin

      v = vec_base + VW'(2 * i);
      // level 0 leaves a channel disabled
      if (irq_req[i] && !route_to_coprocessor[i] && chan_lvl[i] != 3'h0) begin
        if (!cpu_any || chan_lvl[i] > cpu_best_lvl ||
            (chan_lvl[i] == cpu_best_lvl && v > cpu_best_vec)) begin
          cpu_any = 1'b1;
          cpu_best_lvl = chan_lvl[i];
          cpu_best_vec = v;
        end
      end
    end
    for (int i = 0; i < NUM_CHAN; i++) begin
      v = cp_vec_base + VW'(2 * i);

      // level 0 in the shared priority blocks all raised irqs
      if (cp_flag[i] &&
          route_to_coprocessor[i] &&
          coprocessor_irq_enable &&
          coprocessor_irq_priority_cfg != 3'h0) begin
        // shared level; ties go to the higher vector address
        if (!cpu_any || coprocessor_irq_priority_cfg > cpu_best_lvl ||
            (coprocessor_irq_priority_cfg == cpu_best_lvl && v > cpu_best_vec)) begin
          cpu_any = 1'b1;
          cpu_best_lvl = coprocessor_irq_priority_cfg;
          cpu_best_vec = v;
        end
      end
    end
  end

  // coprocessor decoder: no thread level input exists on purpose;
  // the far end weighs the handed priority bit against its own thread,
  // so a low-level request may be presented while it cannot preempt
  logic cp_any;
  logic [2:0] cp_best_lvl;
  logic [CW-1:0] cp_best_chan;
  always_comb begin
    cp_any = 1'b0;
    cp_best_lvl = 3'h0;
    cp_best_chan = '0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (irq_req[i] && route_to_coprocessor[i] && chan_lvl[i] != 3'h0) begin
        // >= lets the higher channel win a tie, so the pick is unique
        if (!cp_any || chan_lvl[i] >= cp_best_lvl) begin
          cp_any = 1'b1;
          cp_best_lvl = chan_lvl[i];
          cp_best_chan = CW'(i);
        end
      end
    end
  end

  // events
  wire logic vec_fetch = cpu_vec_req;
  wire logic ev_spur = vec_fetch & ~cpu_any;
  wire logic ev_override = vec_fetch &
      cpu_any &
      recog_valid &
      (cpu_best_vec != recog_vec);
  wire logic ev_cp_taken = cp_req_ack & cp_req_valid;
  wire logic [cprpd_pkg::ST_W-1:0] ev_set = {
      ev_cp_taken, // status bit 3
      ev_override, // status bit 2
      ev_spur, // status bit 1
      vec_fetch // status bit 0
  };
  wire logic [cprpd_pkg::ST_W-1:0] next_status =
      ((rd_done && hit_status) ? '0 : irq_status) |
      ev_set;

  // read mux
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (chan_hit) begin
      rd_val[cprpd_pkg::CFG_ROUTE_BIT] = route_to_coprocessor[chan_idx];
      rd_val[cprpd_pkg::CFG_LVL_LSB +: cprpd_pkg::CFG_LVL_W] = chan_lvl[chan_idx];
    end else if (hit_ctrl) begin
      rd_val[cprpd_pkg::CTRL_IRQ_EN_BIT] = coprocessor_irq_enable;
    end else if (hit_prio) begin
      rd_val[2:0] = coprocessor_irq_priority_cfg;
    end else if (hit_vbase) begin
      rd_val[VW-1:0] = vec_base;
    end else if (hit_cpvbase) begin
      rd_val[VW-1:0] = cp_vec_base;
    end else if (hit_spur) begin
      rd_val[VW-1:0] = spur_vec;
    end else if (hit_status) begin
      rd_val[cprpd_pkg::ST_W-1:0] = irq_status;
    end else if (hit_mask) begin
      rd_val[cprpd_pkg::ST_W-1:0] = irq_mask;
    end else if (hit_cpu_st) begin
      rd_val[VW-1:0] = cpu_best_vec;
      rd_val[18:16] = cpu_best_lvl;
      rd_val[20] = cpu_any;
    end else if (hit_cp_st) begin
      rd_val[CW-1:0] = cp_best_chan;
      rd_val[18:16] = cp_best_lvl;
      rd_val[20] = cp_any;
    end
  end

  // apb handshake: one wait-free access phase after setup;
  // read data is latched at setup, so a status read shows
  // the bits as they stood before its own clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~addr_ok;
      if (setup_ph) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // per-channel configuration
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chan_lvl[g] <= cprpd_pkg::RST_LVL;
        route_to_coprocessor[g] <= 1'b0;
      end else if (wr_done && chan_hit && chan_idx == CW'(g)) begin
        chan_lvl[g] <= pwdata[cprpd_pkg::CFG_LVL_LSB +: cprpd_pkg::CFG_LVL_W];
        route_to_coprocessor[g] <= pwdata[cprpd_pkg::CFG_ROUTE_BIT];
      end
    end
  end

  // global configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coprocessor_irq_enable <= 1'b0;
      coprocessor_irq_priority_cfg <= cprpd_pkg::RST_CP_PRIO;
      vec_base <= cprpd_pkg::RST_VEC_BASE;
      cp_vec_base <= cprpd_pkg::RST_CP_VEC_BASE;
      spur_vec <= cprpd_pkg::RST_SPUR_VEC;
      irq_mask <= cprpd_pkg::RST_MASK;
    end else if (wr_done) begin
      if (hit_ctrl) begin
        coprocessor_irq_enable <= pwdata[cprpd_pkg::CTRL_IRQ_EN_BIT];
      end
      if (hit_prio) begin
        coprocessor_irq_priority_cfg <= pwdata[2:0];
      end
      // bit 0 dropped: vectors stay on word boundaries
      if (hit_vbase) begin
        vec_base <= {pwdata[VW-1:1], 1'b0};
      end
      if (hit_cpvbase) begin
        cp_vec_base <= {pwdata[VW-1:1], 1'b0};
      end
      if (hit_spur) begin
        spur_vec <= {pwdata[VW-1:1], 1'b0};
      end
      if (hit_mask) begin
        irq_mask <= pwdata[cprpd_pkg::ST_W-1:0];
      end
    end
  end

  // status: a new event beats the read-clear in the same cycle,
  // so an event in the clearing read's access phase is kept, while one in its setup phase is cleared unread;
  // blk_irq looks at next_status to track status without lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      blk_irq <= 1'b0;
    end else begin
      irq_status <= next_status;
      blk_irq <= |(next_status & irq_mask);
    end
  end

  // cpu side: request level is live, vector is sampled only on demand;
  // the cpu may thus get a different vector than the one pending when
  // it saw cpu_irq, or the spurious one if the source has dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq <= 1'b0;
      cpu_irq_level <= 3'h0;
      cpu_vec_valid <= 1'b0;
      cpu_vec <= '0;
      recog_vec <= '0;
      recog_valid <= 1'b0;
    end else begin
      cpu_irq <= cpu_any;
      cpu_irq_level <= cpu_best_lvl;
      cpu_vec_valid <= vec_fetch;
      if (vec_fetch) begin
        // winner evaluated now, not when the request was recognised
        cpu_vec <= cpu_any ? cpu_best_vec : spur_vec;
        recog_valid <= 1'b0;
      end else if (cpu_irq && !recog_valid) begin
        recog_vec <= cpu_best_vec;
        recog_valid <= 1'b1;
      end else if (!cpu_irq) begin
        recog_valid <= 1'b0;
      end
    end
  end

  // coprocessor side: follows the decoder, so stable while winner holds;
  // ack does not retire the request, the source must drop it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp_req_valid <= 1'b0;
      cp_req_chan <= '0;
      cp_req_prio <= 1'b0;
    end else begin
      cp_req_valid <= cp_any;
      cp_req_chan <= cp_best_chan;
      cp_req_prio <= cp_best_lvl[2];
    end
  end
endmodule : cprpd_top
`default_nettype wire

// File: verification/cprpd_checker.sv
// cprpd_checker: port-level timing checks bound into cprpd_top.
// assumes the single pclk domain with async active-low presetn.
`timescale 1ns/1ns
`default_nettype none
module cprpd_checker #(
  parameter int NUM_CHAN = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CHAN-1:0] irq_req,
  input wire logic [NUM_CHAN-1:0] cp_flag,
  input wire logic cpu_irq,
  input wire logic cpu_vec_req,
  input wire logic cpu_vec_valid,
  input wire logic [15:0] cpu_vec,
  input wire logic cp_req_valid,
  input wire logic [$clog2(NUM_CHAN)-1:0] cp_req_chan,
  input wire logic cp_req_prio
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_vec_answer: assert property (cpu_vec_req |=> cpu_vec_valid)
    else $error("vector not answered");
  a_vec_on_demand: assert property (cpu_vec_valid |-> $past(cpu_vec_req))
    else $error("vector without request");
  a_vec_holds: assert property (!cpu_vec_valid |-> $stable(cpu_vec))
    else $error("vector moved between fetches");
  // decoder output lags inputs and config by one cycle each
  a_cp_winner_held: assert property ((!psel && $stable(irq_req)) [*3]
    |-> $stable({cp_req_valid, cp_req_chan, cp_req_prio}))
    else $error("coprocessor winner moved");
  a_cp_needs_req: assert property (irq_req == '0 |=> !cp_req_valid)
    else $error("coprocessor request from nothing");
  a_cpu_idle: assert property ((irq_req == '0 && cp_flag == '0) |=> !cpu_irq)
    else $error("cpu irq from nothing");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("apb not answered");
  a_err_with_ready: assert property (pslverr |-> pready && penable)
    else $error("pslverr outside access");
  c_fetch: cover property (cpu_vec_valid);
  c_cp_high: cover property (cp_req_valid && cp_req_prio);
  c_refused: cover property (pslverr);
endmodule : cprpd_checker
bind cprpd_top cprpd_checker #(.NUM_CHAN(NUM_CHAN)) u_cprpd_checker (.*);
`default_nettype wire

// File: verification/cprpd_far_model.sv
// cprpd_far_model: coprocessor end that takes handed-over requests.
// assumes cp_req_* are registered outputs of cprpd_top on pclk.
`timescale 1ns/1ns
`default_nettype none
module cprpd_far_model #(
  parameter int ACK_DLY = 2,
  parameter logic [2:0] RUN_LVL = 3'h2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request hand-over
  input wire logic cp_req_valid,
  input wire logic cp_req_prio,
  output logic cp_req_ack,
  output logic preempt
);
  logic [3:0] wait_cnt;
  // only a bit-set request displaces a level 1..3 thread
  assign preempt = cp_req_valid && cp_req_prio && (RUN_LVL inside {[1:3]});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      cp_req_ack <= 1'b0;
    end else begin
      cp_req_ack <= cp_req_valid && (wait_cnt == ACK_DLY[3:0]);
      wait_cnt <= cp_req_valid ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : cprpd_far_model
`default_nettype wire

// File: verification/cprpd_top_bench.sv
// cprpd_top_bench: apb, vector-fetch and hand-over sequences with checks.
// assumes cprpd_top with 8 channels and the far model on the cp side.
`timescale 1ns/1ns
`default_nettype none
module cprpd_top_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, cpu_irq, cpu_vec_valid, cp_req_valid, cp_req_prio;
  logic cp_req_ack, blk_irq, preempt;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] cp_flag = 8'h00;
  logic cpu_vec_req = 1'b0;
  logic [2:0] cpu_irq_level, cp_req_chan;
  logic [15:0] cpu_vec;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  always #20 pclk = ~pclk;
  cprpd_top #(.NUM_CHAN(8)) u_cprpd_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .cp_flag(cp_flag),
    .cpu_irq(cpu_irq), .cpu_irq_level(cpu_irq_level), .cpu_vec_req(cpu_vec_req),
    .cpu_vec_valid(cpu_vec_valid), .cpu_vec(cpu_vec), .cp_req_valid(cp_req_valid),
    .cp_req_chan(cp_req_chan), .cp_req_prio(cp_req_prio), .cp_req_ack(cp_req_ack),
    .blk_irq(blk_irq));
  cprpd_far_model u_cprpd_far_model (.pclk(pclk), .presetn(presetn),
    .cp_req_valid(cp_req_valid), .cp_req_prio(cp_req_prio), .cp_req_ack(cp_req_ack),
    .preempt(preempt));
  task tally_and_finish;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task fetch(input logic [15:0] exp);
    @(posedge pclk);
    cpu_vec_req <= 1'b1;
    @(posedge pclk);
    cpu_vec_req <= 1'b0;
    @(posedge pclk);
    chk(cpu_vec_valid, 1'b1);
    chk(cpu_vec, exp);
  endtask : fetch
  // a hang ends in the same closing report
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    tick(6);
    presetn <= 1'b1;
    apb(1'b1, 12'h008, 32'h0000_FF01);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rdat, 32'h0000_FF00);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(rdat, 32'h0000_FE00);
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk({rdat, rerr}, {32'h0000_0000, 1'b1});
    fetch(16'hFF10);
    $display("test reset_map done");
    apb(1'b1, 12'h054, 32'h0000_0002);
    apb(1'b1, 12'h048, 32'h0000_0003);
    irq_req <= 8'h20;
    tick(3);
    chk(cpu_irq, 1'b1);
    irq_req <= 8'h24;
    tick(2);
    chk(cpu_irq_level, 3'h3);
    fetch(16'hFF04);
    irq_req <= 8'h20;
    tick(3);
    irq_req <= 8'h00;
    tick(2);
    fetch(16'hFF10);
    $display("test cpu_override done");
    apb(1'b1, 12'h04C, 32'h0000_0083);
    apb(1'b1, 12'h058, 32'h0000_0085);
    irq_req <= 8'h68;
    tick(3);
    chk({cp_req_valid, cp_req_chan, cp_req_prio}, {1'b1, 3'h6, 1'b1});
    chk(preempt, 1'b1);
    fetch(16'hFF0A);
    irq_req <= 8'h08;
    tick(3);
    chk({cp_req_valid, cp_req_chan, cp_req_prio, cpu_irq}, 6'b1_011_0_0);
    chk(preempt, 1'b0);
    irq_req <= 8'h00;
    $display("test cp_handover done");
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_0004);
    cp_flag <= 8'h4A;
    tick(3);
    chk(cpu_irq_level, 3'h4);
    fetch(16'hFE0C);
    apb(1'b1, 12'h000, 32'h0000_0000);
    tick(2);
    fetch(16'hFF10);
    cp_flag <= 8'h00;
    $display("test cp_raised done");
    apb(1'b1, 12'h018, 32'h0000_0001);
    tick(2);
    chk(blk_irq, 1'b1);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk(rdat, 32'h0000_000F);
    tick(2);
    chk(blk_irq, 1'b0);
    $display("test status_irq done");
    tally_and_finish;
  end
endmodule : cprpd_top_bench
`default_nettype wire
